// *** hw/pqc_pkg.sv ***
package pqc_pkg;
   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      PQC_ENC_X1,
      PQC_ENC_X2,
      PQC_ENC_X4,
      PQC_ENC_TWO_PULSE
   } pqc_enc_t;

   typedef enum logic [1:0] {
      PQC_FN_IDLE,
      PQC_FN_PERIOD,
      PQC_FN_POSITION
   } pqc_fn_t;

   localparam int SYNC_STAGES = 2;
   localparam real CLK_MHZ = 125.0;
endpackage

// *** hw/pqc_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - once armed in period mode, measure one gate period between like active edges.
// - count selected source edges between the two bounding gate edges.
// - offer on-demand count read and sample-clock buffered capture.
// - accept A, B, Z inputs; decoding selectable X1, X2 or X4.
// - X1 counts up on A rise when A leads, down on A fall when B leads.
// - X2 counts on both A edges, direction from lead.
// - X4 counts on every A and B edge, direction from lead.
// - Z high during selected reload phase loads the reload value.
// - reload phase programmable to any of four A/B level combinations.
// - step coinciding with reload phase entry is applied before reload.
// - reload completes one timebase period after phase becomes true, two when a step coincides.
// - after reload, counting continues from reloaded value without re-arm.
// - buffered captures do not clear count; values cumulative since arm.
// - two-pulse mode counts up on A rise, down on B rise.
module pqc_counter
(
   input  wire logic                    clock,
   input  wire logic                    rstn,
   input  wire logic                    arm,
   input  wire logic                    disarm,
   input  wire pqc_pkg::pqc_fn_t        func_sel,
   input  wire pqc_pkg::pqc_enc_t       enc_sel,
   input  wire logic                    gate_falling,
   input  wire logic                    src_falling,
   input  wire logic                    samp_falling,
   input  wire logic                    z_enable,
   input  wire logic [1:0]              reload_phase,
   input  wire logic [pqc_pkg::CNT_W-1:0] reload_value,
   input  wire logic                    read_req,
   input  wire logic                    gate_in,
   input  wire logic                    source_in,
   input  wire logic                    samp_clk_in,
   input  wire logic                    enc_a,
   input  wire logic                    enc_b,
   input  wire logic                    enc_z,
   output logic                         armed,
   output logic [pqc_pkg::CNT_W-1:0]    count_out,
   output logic [pqc_pkg::CNT_W-1:0]    result_out,
   output logic                         result_valid,
   output logic                         period_done
);

   localparam int W = pqc_pkg::CNT_W;

   // two-stage synchronisers, then one history stage for edge detection
   logic [5:0] s1_reg;
   logic [5:0] s2_reg;
   logic [5:0] s3_reg;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_reg <= 6'h00;
         s2_reg <= 6'h00;
         s3_reg <= 6'h00;
      end
      else
      begin
         s1_reg <= {gate_in, source_in, samp_clk_in, enc_a, enc_b, enc_z};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   logic a_now, b_now, z_now, a_old, b_old;
   logic g_now, g_old, s_now, s_old, c_now, c_old;
   assign {g_now, s_now, c_now, a_now, b_now, z_now} = s2_reg;
   assign {g_old, s_old, c_old, a_old, b_old}        = s3_reg[5:1];

   logic a_rise, a_fall, b_rise, b_fall;
   assign a_rise = a_now & ~a_old;
   assign a_fall = ~a_now & a_old;
   assign b_rise = b_now & ~b_old;
   assign b_fall = ~b_now & b_old;

   logic gate_edge, src_edge, samp_edge;
   assign gate_edge = gate_falling ? (g_old & ~g_now) : (g_now & ~g_old);
   assign src_edge  = src_falling  ? (s_old & ~s_now) : (s_now & ~s_old);
   assign samp_edge = samp_falling ? (c_old & ~c_now) : (c_now & ~c_old);

   // quadrature direction: A edge with B low after A rise means A leads
   logic step_up, step_dn;
   always_comb
   begin
      step_up = 1'b0;
      step_dn = 1'b0;
      case (enc_sel)
         pqc_pkg::PQC_ENC_X1:
         begin
            step_up = a_rise & ~b_now;
            step_dn = a_fall & ~b_now;
         end
         pqc_pkg::PQC_ENC_X2:
         begin
            step_up = (a_rise & ~b_now) | (a_fall & b_now);
            step_dn = (a_fall & ~b_now) | (a_rise & b_now);
         end
         pqc_pkg::PQC_ENC_X4:
         begin
            step_up = (a_rise & ~b_now) | (a_fall & b_now)
                    | (b_rise & a_now) | (b_fall & ~a_now);
            step_dn = (a_fall & ~b_now) | (a_rise & b_now)
                    | (b_rise & ~a_now) | (b_fall & a_now);
         end
         pqc_pkg::PQC_ENC_TWO_PULSE:
         begin
            step_up = a_rise & ~b_rise;
            step_dn = b_rise & ~a_rise;
         end
         default:
         begin
            step_up = 1'b0;
            step_dn = 1'b0;
         end
      endcase
   end

   // phase is judged on the live sample, not the history stage
   logic in_phase, do_reload;
   assign in_phase  = ({a_now, b_now} == reload_phase);
   assign do_reload = z_enable & z_now & in_phase;

   // arm state
   logic armed_reg;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         armed_reg <= 1'b0;
      else if (disarm)
         armed_reg <= 1'b0;
      else if (arm)
         armed_reg <= 1'b1;
   end
   assign armed = armed_reg;

   logic pos_mode, per_mode;
   assign pos_mode = armed_reg & (func_sel == pqc_pkg::PQC_FN_POSITION);
   assign per_mode = armed_reg & (func_sel == pqc_pkg::PQC_FN_PERIOD);

   // position counter; a step wins its cycle, a coinciding reload lands one cycle later
   // so the step is never swallowed
   logic [W-1:0] pos_reg;
   logic [W-1:0] pos_next;
   logic         step_pend_reg;
   always_comb
   begin
      pos_next = pos_reg;
      if (step_up)
         pos_next = pos_reg + 1'b1;
      else if (step_dn)
         pos_next = pos_reg - 1'b1;
      else if (do_reload || step_pend_reg)
         pos_next = reload_value;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pos_reg <= pqc_pkg::CNT_RST;
      else if (arm && !armed_reg)
         pos_reg <= pqc_pkg::CNT_RST;
      else if (pos_mode)
         pos_reg <= pos_next;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         step_pend_reg <= 1'b0;
      else
         step_pend_reg <= pos_mode & (step_up | step_dn) & (do_reload | step_pend_reg);
   end

   // period measurement
   typedef enum logic [1:0] {
      PQC_P_WAIT,
      PQC_P_COUNT,
      PQC_P_DONE
   } pqc_pstate_t;
   pqc_pstate_t pst_reg;
   logic [W-1:0] per_cnt_reg;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pst_reg <= PQC_P_WAIT;
      else if (!per_mode)
         pst_reg <= PQC_P_WAIT;
      else
      begin
         case (pst_reg)
            PQC_P_WAIT:  if (gate_edge) pst_reg <= PQC_P_COUNT;
            PQC_P_COUNT: if (gate_edge) pst_reg <= PQC_P_DONE;
            PQC_P_DONE:  pst_reg <= PQC_P_DONE;
            default:     pst_reg <= PQC_P_WAIT;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         per_cnt_reg <= pqc_pkg::CNT_RST;
      else if (pst_reg == PQC_P_WAIT)
         per_cnt_reg <= pqc_pkg::CNT_RST;
      else if (pst_reg == PQC_P_COUNT && src_edge)
         per_cnt_reg <= per_cnt_reg + 1'b1;
   end

   // outputs
   logic [W-1:0] count_reg;
   logic [W-1:0] result_reg;
   logic         valid_reg;
   logic         done_reg;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         count_reg <= pqc_pkg::CNT_RST;
      else
         count_reg <= pos_reg;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         result_reg <= pqc_pkg::CNT_RST;
         valid_reg  <= 1'b0;
         done_reg   <= 1'b0;
      end
      else
      begin
         valid_reg <= 1'b0;
         done_reg  <= 1'b0;
         if (per_mode && pst_reg == PQC_P_COUNT && gate_edge)
         begin
            // an edge on the same sample as the closing gate edge is counted
            result_reg <= per_cnt_reg + {{(W-1){1'b0}}, src_edge};
            valid_reg  <= 1'b1;
            done_reg   <= 1'b1;
         end
         else if (pos_mode && (samp_edge || read_req))
         begin
            result_reg <= pos_reg;
            valid_reg  <= 1'b1;
         end
      end
   end

   assign count_out    = count_reg;
   assign result_out   = result_reg;
   assign result_valid = valid_reg;
   assign period_done  = done_reg;

   property p_unarmed_hold;
      @(posedge clock) disable iff (!rstn)
         (!armed_reg && !arm) |=> $stable(pos_reg);
   endproperty
   a_unarmed_hold: assert property (p_unarmed_hold) else $error("count moved unarmed");

   property p_reload;
      @(posedge clock) disable iff (!rstn)
         (pos_mode && (do_reload || step_pend_reg) && !step_up && !step_dn && !disarm)
            |=> (pos_reg == $past(reload_value));
   endproperty
   a_reload: assert property (p_reload) else $error("reload missed");

   property p_step_first;
      @(posedge clock) disable iff (!rstn)
         (pos_mode && !disarm && do_reload && step_up) |=> (pos_reg == $past(pos_reg) + 1'b1);
   endproperty
   a_step_first: assert property (p_step_first) else $error("step lost to reload");

   property p_x1_up;
      @(posedge clock) disable iff (!rstn)
         (pos_mode && !disarm && enc_sel == pqc_pkg::PQC_ENC_X1 && a_rise && !b_now
          && !do_reload) |=> (pos_reg == $past(pos_reg) + 1'b1);
   endproperty
   a_x1_up: assert property (p_x1_up) else $error("x1 increment wrong");

   property p_x2_dn;
      @(posedge clock) disable iff (!rstn)
         (pos_mode && !disarm && enc_sel == pqc_pkg::PQC_ENC_X2 && a_rise && b_now
          && !do_reload) |=> (pos_reg == $past(pos_reg) - 1'b1);
   endproperty
   a_x2_dn: assert property (p_x2_dn) else $error("x2 decrement wrong");

   property p_x4_b;
      @(posedge clock) disable iff (!rstn)
         (pos_mode && !disarm && enc_sel == pqc_pkg::PQC_ENC_X4 && b_rise && a_now
          && !a_rise && !a_fall && !do_reload) |=> (pos_reg == $past(pos_reg) + 1'b1);
   endproperty
   a_x4_b: assert property (p_x4_b) else $error("x4 b edge wrong");

   property p_two_pulse;
      @(posedge clock) disable iff (!rstn)
         (pos_mode && !disarm && enc_sel == pqc_pkg::PQC_ENC_TWO_PULSE && b_rise
          && !a_rise && !do_reload) |=> (pos_reg == $past(pos_reg) - 1'b1);
   endproperty
   a_two_pulse: assert property (p_two_pulse) else $error("two-pulse down wrong");

   property p_sample;
      @(posedge clock) disable iff (!rstn)
         (pos_mode && samp_edge) |=> (valid_reg && result_reg == $past(pos_reg));
   endproperty
   a_sample: assert property (p_sample) else $error("sample capture wrong");

   property p_period_end;
      @(posedge clock) disable iff (!rstn)
         (per_mode && pst_reg == PQC_P_COUNT && gate_edge) |=> done_reg ##1 !done_reg;
   endproperty
   a_period_end: assert property (p_period_end) else $error("period done missing");

   property p_count_src;
      @(posedge clock) disable iff (!rstn)
         (per_mode && pst_reg == PQC_P_COUNT && !gate_edge && src_edge)
            |=> (per_cnt_reg == $past(per_cnt_reg) + 1'b1);
   endproperty
   a_count_src: assert property (p_count_src) else $error("source edge lost");

endmodule
`default_nettype wire

// *** test/pqc_src_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pqc_src_model
(
   input  wire logic clock,
   output logic      enc_a,
   output logic      enc_b,
   output logic      enc_z,
   output logic      gate_in,
   output logic      source_in,
   output logic      samp_clk_in
);
   initial {enc_a, enc_b, enc_z, gate_in, source_in, samp_clk_in} = 6'h00;

   // pins move on the falling edge and then rest long enough for the
   // two-stage sync and the count update, so edges never pile up
   task automatic put(input logic [5:0] p, input int n);
      @(negedge clock);
      {enc_a, enc_b, enc_z, gate_in, source_in, samp_clk_in} = p;
      repeat (n) @(negedge clock);
   endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
   logic              clock = 1'b0;
   logic              rstn = 1'b0;
   logic              arm = 1'b0;
   logic              disarm = 1'b0;
   logic              gate_falling = 1'b0;
   logic              src_falling = 1'b0;
   logic              samp_falling = 1'b0;
   logic              z_enable = 1'b0;
   logic              read_req = 1'b0;
   logic [1:0]        reload_phase = 2'h0;
   logic [31:0]       reload_value = 32'h0;
   pqc_pkg::pqc_fn_t  func_sel = pqc_pkg::PQC_FN_IDLE;
   pqc_pkg::pqc_enc_t enc_sel = pqc_pkg::PQC_ENC_X1;
   wire logic         enc_a, enc_b, enc_z, gate_in, source_in, samp_clk_in;
   wire logic [5:0]   pins;
   logic              armed, result_valid, period_done;
   logic [31:0]       count_out, result_out, exp_cnt, w;
   logic [31:0]       exp_q [$];
   logic [1:0]        ab = 2'h0;
   bit                trk;
   int                qi, fails, n_checks, cycles, seed, k [3];
   localparam logic [1:0] SEQ [4] = '{2'h0, 2'h2, 2'h3, 2'h1};

   assign pins = {enc_a, enc_b, enc_z, gate_in, source_in, samp_clk_in};
   always #4 clock = ~clock;

   pqc_counter i_dut (.clock, .rstn, .arm, .disarm, .func_sel, .enc_sel, .gate_falling,
      .src_falling, .samp_falling, .z_enable, .reload_phase, .reload_value, .read_req,
      .gate_in, .source_in, .samp_clk_in, .enc_a, .enc_b, .enc_z, .armed, .count_out,
      .result_out, .result_valid, .period_done);
   pqc_src_model i_src (.clock, .enc_a, .enc_b, .enc_z, .gate_in, .source_in, .samp_clk_in);

   function automatic int dlt(logic [1:0] o, logic [1:0] n);
      logic ae, be, up;
      ae = o[1] ^ n[1];
      be = o[0] ^ n[0];
      up = n[1] ^ n[0];
      case (enc_sel)
         pqc_pkg::PQC_ENC_X1: return ae ? int'(n == 2'h2) - int'(n == 2'h0) : 0;
         pqc_pkg::PQC_ENC_X2: return ae ? (up ? 1 : -1) : 0;
         pqc_pkg::PQC_ENC_X4: return (ae | be) ? ((up ^ be) ? 1 : -1) : 0;
         default: return int'(ae & n[1]) - int'(be & n[0]);
      endcase
   endfunction

   task automatic pin(input logic [5:0] m);
      i_src.put(pins ^ m, 5);
   endtask

   // zt toggles the index line along with the step
   task automatic move(input logic [1:0] n, input logic zt = 1'b0);
      if (trk)
         exp_cnt = exp_cnt + 32'(dlt(ab, n));
      pin({pins[5:4] ^ n, zt, 3'h0});
      ab = n;
      if (trk && z_enable && enc_z && ab == reload_phase)
         exp_cnt = reload_value;
   endtask

   task automatic step_q(input logic fwd);
      qi = (qi + (fwd ? 1 : 3)) % 4;
      move(SEQ[qi]);
   endtask

   task automatic rearm(input pqc_pkg::pqc_fn_t f, input pqc_pkg::pqc_enc_t e);
      @(negedge clock);
      disarm = 1'b1;
      @(negedge clock);
      disarm = 1'b0;
      func_sel = f;
      enc_sel = e;
      arm = 1'b1;
      @(negedge clock);
      arm = 1'b0;
      exp_cnt = 32'h0;
      `CHK("armed", 1'b1, armed)
   endtask

   task automatic capture();
      @(negedge clock);
      read_req = 1'b1;
      exp_q.push_back(exp_cnt);
      @(negedge clock);
      read_req = 1'b0;
      repeat (3) @(negedge clock);
      `CHK("count_out", exp_cnt, count_out)
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clock)
   begin
      if (period_done === 1'b1)
         `CHK("period_done", 1'b1, result_valid)
      if (result_valid === 1'b1)
      begin
         w = (exp_q.size() != 0) ? exp_q.pop_front() : ~result_out;
         `CHK("result_out", w, result_out)
         `CHK("period_done", (func_sel == pqc_pkg::PQC_FN_PERIOD), period_done)
      end
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         print_verdict();
      end
   end

   initial
   begin
      seed = 21;
      repeat (3) @(negedge clock);
      rstn = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         rearm(pqc_pkg::PQC_FN_POSITION, pqc_pkg::pqc_enc_t'(m));
         trk = 1'b1;
         for (int i = 0; i < 12; i++)
            if (m == 3)
            begin
               move(($random(seed) & 1) ? 2'h2 : 2'h1);
               move(2'h0);
            end
            else
               step_q(1'($random(seed)));
         capture();
         $display("encoder mode %0d done", m);
      end
      qi = 0;
      @(negedge clock);
      disarm = 1'b1;
      @(negedge clock);
      disarm = 1'b0;
      trk = 1'b0;
      repeat (6) step_q(1'b1);
      `CHK("count_out", exp_cnt, count_out)
      `CHK("armed", 1'b0, armed)
      $display("unarmed test done");
      rearm(pqc_pkg::PQC_FN_POSITION, pqc_pkg::PQC_ENC_X4);
      trk = 1'b1;
      for (int j = 0; j < 3; j++)
      begin
         repeat (5) step_q(1'b1);
         samp_falling = j[0];
         exp_q.push_back(exp_cnt);
         pin(6'h01);
         pin(6'h01);
      end
      $display("sample capture test done");
      z_enable = 1'b1;
      for (int p = 0; p < 4; p++)
      begin
         reload_phase = 2'(p);
         reload_value = $random(seed);
         rearm(pqc_pkg::PQC_FN_POSITION, pqc_pkg::PQC_ENC_X4);
         move(ab, 1'b1);
         repeat (4) step_q(1'b1);
         move(ab, 1'b1);
         repeat (3) step_q(1'b0);
         capture();
      end
      z_enable = 1'b0;
      trk = 1'b0;
      $display("index reload test done");
      for (int f = 0; f < 4; f++)
      begin
         gate_falling = f[0];
         src_falling = f[1];
         rearm(pqc_pkg::PQC_FN_PERIOD, enc_sel);
         foreach (k[i])
            k[i] = ($random(seed) & 3) + 1;
         exp_q.push_back(32'(gate_falling ? k[1] + k[2] : k[0] + k[1]));
         for (int t = 0; t < 4; t++)
         begin
            pin(6'h04);
            if (t < 3)
               repeat (k[t])
               begin
                  pin(6'h02);
                  pin(6'h02);
               end
         end
      end
      repeat (10) @(negedge clock);
      `CHK("queue left", 32'h0, 32'(exp_q.size()))
      $display("period test done");
      print_verdict();
   end
endmodule
`default_nettype wire
